// ### core/adc_seq.sv
// Serial control sequencer of a 10-bit successive-approximation converter.
// Assumes clk_in is the free-running conversion clock and io_clk_in the host shift clock.
module adc_seq
	import adc_seq_pkg::*;
#(
	parameter int NCH = CHANNELS
) (
	input  wire logic                clk_in,        // Conversion clock, 40 MHz
	input  wire logic                rst_in,        // Synchronous reset, active high
	input  wire logic                io_clk_in,     // Host shift clock
	input  wire logic                select_n_in,   // Device select, active low
	input  wire logic                addr_in,       // Serial channel address
	input  wire sample_s [NCH-1:0]   analog_in,     // Modelled analog inputs
	output logic                     data_out,      // Serial result bit
	output logic                     data_oe_out,   // Result output enable
	output logic                     sampling_out,  // Sample phase active
	output logic                     busy_out,      // Conversion running
	output logic [ADDR_W-1:0]        channel_out    // Channel held for conversion
);

	// Synchronised pins and link toggle
	logic                 fall_tog_sync;
	sample_s [NCH-1:0]    analog_sync;
	logic                 sel_low;
	logic                 fall_evt;

	// Access sequencer state
	acc_state_e           acc_state_reg, acc_state_next;
	logic [1:0]           recog_cnt_reg, recog_cnt_next;
	logic [3:0]           fall_cnt_reg, fall_cnt_next;
	logic                 run_reg, run_next;
	logic                 data_reg, data_next;
	logic                 oe_reg, oe_next;
	logic                 sampling_reg, sampling_next;
	logic [ADDR_W-1:0]    chan_reg, chan_next;
	logic                 fall_prev_reg, fall_prev_next;

	// Conversion engine state
	logic                 busy_reg, busy_next;
	logic [5:0]           conv_cnt_reg, conv_cnt_next;
	logic [RES_W-1:0]     sar_reg, sar_next;
	logic [RES_W-1:0]     held_reg, held_next;
	logic [RES_W-1:0]     result_reg, result_next;
	logic                 abort;
	logic                 start;
	logic                 done;
	logic [RES_W-1:0]     trial;
	logic [3:0]           bit_idx;

	// Link-domain state
	logic [ADDR_W-1:0]    addr_reg, addr_next;
	logic [2:0]           rise_cnt_reg, rise_cnt_next;
	logic                 fall_tog_reg, fall_tog_next;
	logic                 link_clear;

	// Select is inverted ahead of the flops so that their reset value reads as deselected
	sync_2ff #(.W(2 + NCH * $bits(sample_s))) u_sync_in (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   ({~select_n_in, fall_tog_reg, analog_in}),
		.q_out  ({sel_low, fall_tog_sync, analog_sync})
	);

	assign fall_evt = fall_tog_sync ^ fall_prev_reg;

	// Level of the addressed input with clamping at the references
	function automatic logic [RES_W-1:0] pick_level(input logic [ADDR_W-1:0] ch,
	                                                input sample_s [NCH-1:0] ana);
		logic [RES_W-1:0] lvl;
		lvl = RES_ALL_ZEROS;
		if (ch == SELF_TEST_CH) begin
			lvl = SELF_TEST_LVL;
		end else if (ch < ADDR_W'(NCH)) begin
			if (ana[ch].over) begin
				lvl = RES_ALL_ONES;
			end else if (ana[ch].under) begin
				lvl = RES_ALL_ZEROS;
			end else begin
				lvl = ana[ch].level;
			end
		end
		return lvl;
	endfunction

	// Access sequencer and conversion engine next values
	always_comb begin
		acc_state_next = acc_state_reg;
		recog_cnt_next = recog_cnt_reg;
		fall_cnt_next  = fall_cnt_reg;
		run_next       = run_reg;
		data_next      = data_reg;
		oe_next        = oe_reg;
		sampling_next  = sampling_reg;
		chan_next      = chan_reg;
		fall_prev_next = fall_tog_sync;
		busy_next      = busy_reg;
		conv_cnt_next  = conv_cnt_reg;
		sar_next       = sar_reg;
		held_next      = held_reg;
		result_next    = result_reg;
		abort          = 1'b0;
		start          = 1'b0;
		done           = 1'b0;
		bit_idx        = 4'h9 - conv_cnt_reg[5:2];
		trial          = sar_reg | (RES_W'(1) << bit_idx);
		case (acc_state_reg)
			ACC_OFF: begin
				oe_next  = 1'b0;
				run_next = 1'b0;
				if (sel_low) begin
					acc_state_next = ACC_WAIT;
					recog_cnt_next = 2'h0;
				end
			end
			ACC_WAIT: begin
				if (!sel_low) begin
					acc_state_next = ACC_OFF;
				end else if (recog_cnt_reg == 2'(RECOG_RISES)) begin
					acc_state_next = ACC_ON;
					oe_next        = 1'b1;
					data_next      = result_reg[RES_W-1];
					run_next       = 1'b1;
					fall_cnt_next  = 4'h0;
					sampling_next  = 1'b0;
					abort          = busy_reg;
				end else begin
					recog_cnt_next = recog_cnt_reg + 2'h1;
				end
			end
			ACC_ON: begin
				if (!sel_low) begin
					acc_state_next = ACC_OFF;
					oe_next        = 1'b0;
					run_next       = 1'b0;
					sampling_next  = 1'b0;
				end else if (fall_evt && run_reg) begin
					fall_cnt_next = fall_cnt_reg + 4'h1;
					if (fall_cnt_reg < 4'(LAST_FALL - 1)) begin
						data_next = result_reg[4'h8 - fall_cnt_reg];
					end
					if (fall_cnt_reg == 4'(SAMPLE_FALL - 1)) begin
						sampling_next = 1'b1;
						chan_next     = addr_reg;
					end
					if (fall_cnt_reg == 4'(LAST_FALL - 1)) begin
						sampling_next = 1'b0;
						start         = 1'b1;
						run_next      = 1'b0;
					end
				end
			end
			default: begin
				acc_state_next = ACC_OFF;
			end
		endcase
		// Conversion engine, clocked by the conversion clock only
		if (abort) begin
			busy_next = 1'b0;
		end else if (start) begin
			busy_next     = 1'b1;
			conv_cnt_next = 6'h0;
			sar_next      = RES_ALL_ZEROS;
			held_next     = pick_level(chan_reg, analog_sync);
		end else if (busy_reg) begin
			conv_cnt_next = conv_cnt_reg + 6'h1;
			if (conv_cnt_reg[1:0] == 2'h3 && conv_cnt_reg < 6'd40 && held_reg >= trial) begin
				sar_next = trial;
			end
			if (conv_cnt_reg == 6'(CONV_CYCLES - 1)) begin
				busy_next   = 1'b0;
				result_next = sar_reg;
				done        = 1'b1;
			end
		end
		// Selected through a whole conversion: start the next access
		if (done && acc_state_reg == ACC_ON && sel_low) begin
			run_next      = 1'b1;
			fall_cnt_next = 4'h0;
			data_next     = sar_reg[RES_W-1];
		end
		if (rst_in) begin
			acc_state_next = ACC_OFF;
			recog_cnt_next = 2'h0;
			fall_cnt_next  = 4'h0;
			run_next       = 1'b0;
			data_next      = 1'b0;
			oe_next        = 1'b0;
			sampling_next  = 1'b0;
			chan_next      = 4'h0;
			fall_prev_next = 1'b0;
			busy_next      = 1'b0;
			conv_cnt_next  = 6'h0;
			sar_next       = RES_ALL_ZEROS;
			held_next      = RES_ALL_ZEROS;
			result_next    = RESULT_RESET;
		end
	end

	// Conversion-clock registers
	always_ff @(posedge clk_in) begin
		acc_state_reg <= acc_state_next;
		recog_cnt_reg <= recog_cnt_next;
		fall_cnt_reg  <= fall_cnt_next;
		run_reg       <= run_next;
		data_reg      <= data_next;
		oe_reg        <= oe_next;
		sampling_reg  <= sampling_next;
		chan_reg      <= chan_next;
		fall_prev_reg <= fall_prev_next;
		busy_reg      <= busy_next;
		conv_cnt_reg  <= conv_cnt_next;
		sar_reg       <= sar_next;
		held_reg      <= held_next;
		result_reg    <= result_next;
	end

	// Link logic is held clear whenever the sequencer does not accept shifts
	assign link_clear = ~run_reg;

	// Address capture on the first four shift rising edges
	always_comb begin
		addr_next     = addr_reg;
		rise_cnt_next = rise_cnt_reg;
		if (rise_cnt_reg < 3'(ADDR_W)) begin
			addr_next     = {addr_reg[ADDR_W-2:0], addr_in};
			rise_cnt_next = rise_cnt_reg + 3'h1;
		end
		fall_tog_next = ~fall_tog_reg;
	end

	// Shift-clock rising edge registers
	always_ff @(posedge io_clk_in or posedge link_clear) begin
		if (link_clear) begin
			addr_reg     <= 4'h0;
			rise_cnt_reg <= 3'h0;
		end else begin
			addr_reg     <= addr_next;
			rise_cnt_reg <= rise_cnt_next;
		end
	end

	// Each shift falling edge flips a toggle read by the conversion domain
	always_ff @(negedge io_clk_in or posedge link_clear) begin
		if (link_clear) begin
			fall_tog_reg <= 1'b0;
		end else begin
			fall_tog_reg <= fall_tog_next;
		end
	end

	assign data_out     = data_reg;
	assign data_oe_out  = oe_reg;
	assign sampling_out = sampling_reg;
	assign busy_out     = busy_reg;
	assign channel_out  = chan_reg;

	// Helper counts for the window and conversion limits
	logic [3:0]  samp_falls_reg;
	logic [10:0] busy_cyc_reg;
	always_ff @(posedge clk_in) begin
		samp_falls_reg <= (rst_in || !sampling_reg) ? 4'h0 :
		                  samp_falls_reg + {3'h0, fall_evt};
		busy_cyc_reg   <= (rst_in || !busy_reg) ? 11'h0 : busy_cyc_reg + 11'h1;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_release_on_deselect;
		!sel_low |=> !data_oe_out;
	endproperty
	a_release_on_deselect: assert property (p_release_on_deselect)
		else $error("output still driven after deselect");
	property p_recognition_delay;
		$rose(data_oe_out) |-> $past(sel_low, 1) && $past(sel_low, 2) && $past(sel_low, 3);
	endproperty
	a_recognition_delay: assert property (p_recognition_delay)
		else $error("select recognised too early");
	property p_msb_first;
		$rose(data_oe_out) |-> data_out == result_reg[RES_W-1];
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("MSB not presented at recognition");
	property p_bit_order;
		acc_state_reg == ACC_ON && sel_low && fall_evt && run_reg && fall_cnt_reg < 4'h9
			|=> data_out == result_reg[4'h8 - $past(fall_cnt_reg)];
	endproperty
	a_bit_order: assert property (p_bit_order)
		else $error("wrong result bit shifted out");
	property p_sample_start;
		acc_state_reg == ACC_ON && sel_low && fall_evt && run_reg && fall_cnt_reg == 4'h3
			|=> sampling_out && channel_out == $past(addr_reg);
	endproperty
	a_sample_start: assert property (p_sample_start)
		else $error("sampling or channel capture missing");
	property p_hold_start;
		acc_state_reg == ACC_ON && sel_low && fall_evt && run_reg && fall_cnt_reg == 4'h9
			|=> !sampling_out && busy_out;
	endproperty
	a_hold_start: assert property (p_hold_start)
		else $error("hold or conversion did not start");
	property p_conv_length;
		busy_out |-> busy_cyc_reg <= 11'(CONV_CYCLES - 1);
	endproperty
	a_conv_length: assert property (p_conv_length)
		else $error("conversion ran past its cycle count");
	property p_conv_end;
		$fell(busy_out) |-> $past(conv_cnt_reg) == 6'd43 || $past(abort);
	endproperty
	a_conv_end: assert property (p_conv_end)
		else $error("conversion ended at wrong cycle");
	property p_conv_limit;
		busy_cyc_reg <= 11'(CONV_LIMIT_CYC);
	endproperty
	a_conv_limit: assert property (p_conv_limit)
		else $error("conversion longer than limit");
	property p_window;
		samp_falls_reg <= 4'(SAMPLE_MAX);
	endproperty
	a_window: assert property (p_window)
		else $error("sampling window too long");
	property p_self_test;
		done && chan_reg == SELF_TEST_CH |=>
			result_reg >= SELF_TEST_MIN && result_reg <= SELF_TEST_MAX;
	endproperty
	a_self_test: assert property (p_self_test)
		else $error("self-test result out of range");
	property p_abort_keeps;
		abort |=> $stable(result_reg) && !busy_out;
	endproperty
	a_abort_keeps: assert property (p_abort_keeps)
		else $error("aborted conversion changed result");
	c_access: cover property ($fell(sampling_out) ##[1:8] busy_out);
	c_abort: cover property (abort);
	c_self_test: cover property (done && chan_reg == SELF_TEST_CH);
	c_full_scale: cover property (done && held_reg == RES_ALL_ONES);

endmodule

// ### core/adc_seq_pkg.sv
// Shared constants, types and timing counts for the serial converter sequencer.
// Assumes a 40 MHz conversion clock and a host-driven shift clock with no phase relation.
// Overview of operation
// - Select high: result output released, address input and shift clock ignored.
// - Select recognised after two rising then one falling conversion-clock edge; code uses only rising edges, recognising on the fourth after sync.
// - On recognition the previous result MSB appears without any shift edge.
// - Host sends 4-bit address MSB first; captured on first four shift rising edges.
// - First four shift falling edges present result bits two to five.
// - Sampling of the newly addressed channel starts after the fourth falling edge.
// - Falling edges five to nine present bits six to ten, LSB last.
// - Tenth falling edge ends sampling, holds, converts over next 44 conversion cycles.
// - Sampling window spans at most six shift cycles, fourth to tenth edge.
// - Address 1011 converts internal self-test level, result within 500 to 524.
// - Addresses and results are positive logic, high means one.
// - Input above upper reference gives all ones, below lower gives zeros.
// - Shift and conversion clocks independent; conversion runs on conversion clock only.
// - Conversion finishes within 21 us; full cycle repeatable every 31 us.
// - Select held high until conversion ends; recognised falling select aborts conversion.
// - Aborted conversion leaves the last completed result for output.
package adc_seq_pkg;

	localparam int RES_W       = 10;
	localparam int ADDR_W      = 4;
	localparam int CHANNELS    = 11;
	localparam int RECOG_RISES = 2;
	localparam int SAMPLE_FALL = 4;
	localparam int LAST_FALL   = 10;
	localparam int SAMPLE_MAX  = 6;
	localparam int CONV_CYCLES = 44;

	localparam logic [ADDR_W-1:0] SELF_TEST_CH   = 4'hb;
	localparam logic [RES_W-1:0]  SELF_TEST_LVL  = 10'h200;
	localparam logic [RES_W-1:0]  SELF_TEST_MIN  = 10'h1f4;
	localparam logic [RES_W-1:0]  SELF_TEST_MAX  = 10'h20c;
	localparam logic [RES_W-1:0]  RES_ALL_ONES   = 10'h3ff;
	localparam logic [RES_W-1:0]  RES_ALL_ZEROS  = 10'h000;
	localparam logic [RES_W-1:0]  RESULT_RESET   = 10'h000;

	// Timing figures and derived cycle counts (longest times round down)
	localparam int CLK_KHZ         = 40000;
	localparam int CONV_TIME_NS    = 21000;
	localparam int ACCESS_TIME_NS  = 31000;
	localparam int CONV_LIMIT_CYC  = CONV_TIME_NS * (CLK_KHZ / 1000) / 1000;
	localparam int ACCESS_LIMIT_CYC = ACCESS_TIME_NS * (CLK_KHZ / 1000) / 1000;

	// Access sequencer states
	typedef enum logic [1:0] {
		ACC_OFF,
		ACC_WAIT,
		ACC_ON
	} acc_state_e;

	// One analog input as seen by the converter model
	typedef struct packed {
		logic             over;
		logic             under;
		logic [RES_W-1:0] level;
	} sample_s;

endpackage

// ### core/sync_2ff.sv
// Two flip-flop level synchroniser, parameterised width.
// Assumes each bit is an independent level or a slow toggle.
module sync_2ff #(
	parameter int W = 1
) (
	input  wire logic         clk_in, // Destination clock
	input  wire logic         rst_in, // Synchronous reset, active high
	input  wire logic [W-1:0] d_in,   // Asynchronous level
	output logic      [W-1:0] q_out   // Synchronised level
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	// Next values of both stages
	always_comb begin
		meta_next = rst_in ? '0 : d_in;
		q_next    = rst_in ? '0 : meta_reg;
	end

	// Registers of both stages
	always_ff @(posedge clk_in) begin
		meta_reg <= meta_next;
		q_reg    <= q_next;
	end

	assign q_out = q_reg;

endmodule

// ### testbench/host_model.sv
// Host model: drives select, shift clock and address bits of the sequencer.
// Assumes clk_in is the conversion clock, used only to place the select edges and the wait before shifting.
module host_model (
	input  wire logic clk_in,       // Conversion clock
	input  wire logic data_in,      // Serial result bit
	output logic      select_n_out, // Device select, active low
	output logic      io_clk_out,   // Shift clock, low outside frames except for stray pulses
	output logic      addr_out      // Serial address bit
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle state: deselected, shift clock low
	initial begin
		select_n_out = 1'b1;
		io_clk_out   = 1'b0;
		addr_out     = 1'b0;
	end

	// One access: select, wait for recognition, then the shift pulses
	task automatic frame(input logic [3:0] ch, input int n, output logic [9:0] rd);
		@(posedge clk_in);
		#2 select_n_out = 1'b0;
		repeat (8) @(posedge clk_in);
		#7;
		shift_bits(ch, n, rd);
	endtask

	// Address in, n shift pulses of 125 ns, result bits out, on a recognised select
	task automatic shift_bits(input logic [3:0] ch, input int n, output logic [9:0] rd);
		rd = 10'h000;
		for (int k = 0; k < n; k++) begin
			addr_out = (k < 4) ? ch[3 - k] : ~addr_out;
			#62.5 io_clk_out = 1'b1;
			#62.5;
			// Bit read just before the fall that replaces it
			if (k < 10) begin
				rd[9 - k] = data_in;
			end
			io_clk_out = 1'b0;
		end
		addr_out = ~addr_out;
	endtask

	// Raise select and keep it high; shift clock stays low meanwhile
	task automatic deselect(input int cycles);
		@(posedge clk_in);
		#2 select_n_out = 1'b1;
		repeat (cycles) @(posedge clk_in);
	endtask

	// Shift pulses while deselected, as on lines shared with other devices
	task automatic stray(input int n);
		repeat (n) begin
			#62.5 io_clk_out = 1'b1;
			addr_out = ~addr_out;
			#62.5 io_clk_out = 1'b0;
		end
	endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench of the converter sequencer with a host model on the link.
// Assumes adc_seq_pkg, adc_seq and host_model are compiled before it.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import adc_seq_pkg::*;

	logic                      clk        = 1'b0;
	logic                      rst        = 1'b1;
	logic                      sel_n;
	logic                      io_clk;
	logic                      addr;
	sample_s [CHANNELS-1:0]    ana        = '0;
	logic                      data;
	logic                      pin;
	logic                      data_oe;
	logic                      sampling;
	logic                      busy;
	logic [ADDR_W-1:0]         chan;
	logic [RES_W-1:0]          rd;
	int                        num_errors = 0;
	int                        n_tests    = 0;
	int                        cycles     = 0;
	int                        samp_len   = 0;

	// Conversion clock, 40 MHz
	always #12.5 clk = ~clk;

	adc_seq i_dut (
		.clk_in       (clk),
		.rst_in       (rst),
		.io_clk_in    (io_clk),
		.select_n_in  (sel_n),
		.addr_in      (addr),
		.analog_in    (ana),
		.data_out     (data),
		.data_oe_out  (data_oe),
		.sampling_out (sampling),
		.busy_out     (busy),
		.channel_out  (chan)
	);

	// Result line as the host sees it; a released line reads as the inverse
	assign pin = data_oe ? data : ~data;

	host_model i_host (
		.clk_in       (clk),
		.data_in      (pin),
		.select_n_out (sel_n),
		.io_clk_out   (io_clk),
		.addr_out     (addr)
	);

	// Cycle ceiling against hangs, and length of the sampling phase per access
	always @(posedge clk) begin
		cycles <= cycles + 1;
		samp_len <= sel_n ? 0 : samp_len + int'(sampling);
		if (cycles == 20000) begin
			num_errors++;
			$display("BAD %0t timeout got %h exp %h", $time, cycles, 0);
			conclude();
		end
	end

	// Compares one value and counts the outcome
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Waits for a conversion to start and returns how many cycles it ran
	task automatic conv_len(output int len);
		len = 0;
		for (int i = 0; i < 10 && busy !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		while (busy === 1'b1 && len < 100) begin
			@(posedge clk);
			#1;
			len++;
		end
	endtask

	// Deselected device ignores shift pulses and keeps its output released
	task automatic t_idle();
		check(data_oe, 1'b0);
		i_host.stray(6);
		repeat (10) @(posedge clk);
		#1;
		check(data_oe, 1'b0);
		check(sampling, 1'b0);
		check(busy, 1'b0);
		check(chan, 4'h0);
		$display("test idle done");
	endtask

	// Chain of accesses, the first reading the reset result and each later one the result of the one before
	task automatic t_chain();
		logic [3:0] chs [5] = '{4'h3, SELF_TEST_CH, 4'h5, 4'h6, 4'h0};
		logic [9:0] exp [5] = '{10'h000, 10'h2a5, 10'h000, 10'h3ff, 10'h000};
		int len;
		for (int k = 0; k < 5; k++) begin
			i_host.frame(chs[k], 10, rd);
			if (k == 2) begin
				check(10'(rd >= SELF_TEST_MIN && rd <= SELF_TEST_MAX), 10'h001);
			end else begin
				check(rd, exp[k]);
			end
			check(data_oe, 1'b1);
			check(chan, chs[k]);
			conv_len(len);
			check(10'(len), 10'd44);
			check(10'(samp_len >= 29 && samp_len <= 31), 10'h001);
			i_host.deselect(10);
			check(data_oe, 1'b0);
		end
		$display("test chain done");
	endtask

	// New access during a conversion aborts it and returns the older result
	task automatic t_abort();
		int len;
		i_host.frame(4'h1, 10, rd);
		check(rd, 10'h0f0);
		i_host.deselect(6);
		i_host.frame(4'h2, 10, rd);
		check(rd, 10'h0f0);
		conv_len(len);
		check(10'(len), 10'd44);
		i_host.deselect(10);
		i_host.frame(4'h2, 10, rd);
		check(rd, 10'h0cc);
		conv_len(len);
		check(10'(len), 10'd44);
		i_host.deselect(10);
		$display("test abort done");
	endtask

	// Select held low through a conversion: the next access follows without a new select
	task automatic t_held();
		int len;
		i_host.frame(4'h1, 10, rd);
		check(rd, 10'h0cc);
		conv_len(len);
		check(10'(len), 10'd44);
		check(data_oe, 1'b1);
		i_host.shift_bits(4'h2, 10, rd);
		check(rd, 10'h155);
		check(chan, 4'h2);
		conv_len(len);
		check(10'(len), 10'd44);
		i_host.deselect(10);
		check(data_oe, 1'b0);
		$display("test held done");
	endtask

	// Prints the counts and the verdict, then ends the run
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Analog setup, reset, then the scenarios in order
	initial begin
		ana[3].level = 10'h2a5;
		ana[5].over  = 1'b1;
		ana[6].under = 1'b1;
		ana[6].level = 10'h3ff;
		ana[0].level = 10'h0f0;
		ana[1].level = 10'h155;
		ana[2].level = 10'h0cc;
		repeat (5) @(posedge clk);
		#2 rst = 1'b0;
		t_idle();
		t_chain();
		t_abort();
		t_held();
		conclude();
	end
endmodule
